//--- hw/sysctl_pkg.sv
/*
  Constants for the system control and DRAM test-access register bank.
  Assumes a byte-wide direct I/O port with a 16-bit address.
*/
// How it works
// RQ1: bit 7 written one enters soft reset; zero leaves it, ports stay disabled.
// RQ2: soft reset clears only the port control register.
// RQ3: any write in 4000-7FFF acts as hardware reset of configuration.
// RQ4: load bit one starts EEPROM auto-load of registers 00 through C3.
// RQ5: load reads one until done, is never loaded, zero write ignored.
// RQ6: start bit begins operation, reads one during buffer init, ports disabled.
// RQ7: stats clear repeats while the bit stays one.
// RQ8: stat select one counts TX resource discards, zero TX data errors.
// RQ9: on violation, disable port if violation disable set, else suspend.
// RQ10: suspended port auto re-enables; disabled port needs management enable.
// RQ11: long bit widens top size bucket to 1531 bytes, else 1518.
// RQ12: frames of 1536 bytes or more are truncated.
// RQ13: bit 0 in-order broadcast flag is read-only, always one.
// RQ14: test data word maps to buffer forward-pointer field.
// RQ15: activity bit 7 of flag register high while test access runs.
// RQ16: host waits for activity to fall before using read data.
// RQ17: four-bit test flag maps to buffer flag field.
// RQ18: address bit 23 high writes, low reads DRAM.
// RQ19: lower 23 address bits give starting word location.
// RQ20: column 7-0, row 15-8, extension bits 16-21 alternate, 22 reserved.
// RQ21: test access starts when address high byte write completes.
// RQ22: host must not rewrite address high byte while active.
package sysctl_pkg;
  localparam logic [15:0] SYSCTL_ADDR = 16'h00D3;
  localparam logic [15:0] DATA_ADDR0 = 16'h00D4;
  localparam logic [15:0] FLAG_ADDR = 16'h00D8;
  localparam logic [15:0] TADDR_ADDR0 = 16'h00D9;
  localparam logic [15:0] TADDR_ADDR2 = 16'h00DB;
  localparam logic [15:0] LOAD_LAST = 16'h00C3;
  localparam logic [1:0] HWRST_TOP = 2'h1;
  localparam int BIT_SWRST = 7;
  localparam int BIT_LOAD = 6;
  localparam int BIT_START = 5;
  localparam int BIT_CLR = 4;
  localparam int BIT_STSEL = 3;
  localparam int BIT_VDIS = 2;
  localparam int BIT_LONG = 1;
  localparam int BIT_IOB = 0;
  localparam int BIT_ACT = 7;
  localparam int BIT_RW = 23;
  localparam logic [7:0] SYSCTL_RST = 8'h01;
  localparam logic [10:0] LONG_MAX = 11'h5FB;
  localparam logic [10:0] NORM_MAX = 11'h5EE;
  localparam logic [10:0] BUCKET_MIN = 11'h400;
  localparam logic [10:0] TRUNC_LEN = 11'h600;
endpackage

//--- hw/viol_port.sv
/*
  Per-port violation handling: disable or suspend.
  Assumes violation level and enable pulses are synchronous.
*/
`timescale 1ns/1ps
module viol_port
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // control
  input wire logic violation_disable,
  input wire logic viol,
  input wire logic mgmt_enable,
  // state
  output logic disabled_r,
  output logic suspended_r
);
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      disabled_r <= 1'b0;
      suspended_r <= 1'b0;
    end
    else if (ce)
    begin
      // RQ9 disable or suspend
      if (viol && violation_disable)
        disabled_r <= 1'b1;
      // RQ10 management re-enable
      else if (mgmt_enable)
        disabled_r <= 1'b0;
      // RQ10 suspend follows condition
      suspended_r <= viol && !violation_disable;
    end
  end
endmodule

//--- hw/size_bucket.sv
/*
  Frame-length classifier for the upper size bucket and truncation.
  Assumes the frame length arrives with a one-cycle valid.
*/
`timescale 1ns/1ps
module size_bucket
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // frame
  input wire logic long_mode,
  input wire logic len_valid,
  input wire logic [10:0] frame_len,
  // result
  output logic bucket_hit_r,
  output logic truncate_r
);
  wire logic [10:0] top_len;
  // RQ11 bucket upper bound
  assign top_len = long_mode ? sysctl_pkg::LONG_MAX : sysctl_pkg::NORM_MAX;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      bucket_hit_r <= 1'b0;
      truncate_r <= 1'b0;
    end
    else if (ce)
    begin
      bucket_hit_r <= len_valid && frame_len >= sysctl_pkg::BUCKET_MIN && frame_len <= top_len;
      // RQ12 truncate long frames
      truncate_r <= len_valid && frame_len >= sysctl_pkg::TRUNC_LEN;
    end
  end
endmodule

//--- hw/sysctl_regs.sv
/*
  System control and DRAM test-access registers on the direct I/O port.
  Assumes byte writes/reads with one-cycle strobes; EEPROM, buffer init
  and DRAM engines report completion by pulses.
*/
`timescale 1ns/1ps
module sysctl_regs
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // direct io port
  input wire logic [15:0] dio_addr,
  input wire logic dio_wr,
  input wire logic dio_rd,
  input wire logic [7:0] dio_wdata,
  output logic [7:0] dio_rdata_r,
  // engine handshakes
  input wire logic load_done,
  input wire logic init_done,
  input wire logic dram_done,
  input wire logic [31:0] dram_rd_data,
  input wire logic [3:0] dram_rd_flag,
  output logic load_go_r,
  output logic dram_go_r,
  output logic dram_write_r,
  output logic [22:0] dram_word_addr_r,
  output logic [31:0] test_data_word_r,
  output logic [3:0] test_flag_field_r,
  // switch control
  output logic hw_reset_r,
  output logic port_ctl_clear_r,
  output logic ports_off_r,
  output logic stats_clear_r,
  output logic stat_select_r,
  // port security
  input wire logic viol,
  input wire logic mgmt_enable,
  output logic port_disabled_r,
  output logic port_suspended_r,
  // frame sizing
  input wire logic len_valid,
  input wire logic [10:0] frame_len,
  output logic bucket_hit_r,
  output logic truncate_r
);
  logic swrst_r, load_r, start_r, clr_r, stsel_r, vdis_r, long_r, running_r;
  logic act_r;
  logic [23:0] taddr_r;
  wire logic hw_wr, sc_wr, d_wr, f_wr, a_wr, ahi_wr;
  wire logic [1:0] dsel, asel;
  wire logic [7:0] sc_val, flag_val, rd_mux;
  wire logic [15:0] doff, aoff;
  wire logic [23:0] taddr_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  // RQ3 hardware reset range
  assign hw_wr = dio_wr && dio_addr[15:14] == sysctl_pkg::HWRST_TOP;
  assign sc_wr = dio_wr && dio_addr == sysctl_pkg::SYSCTL_ADDR;
  assign doff = dio_addr - sysctl_pkg::DATA_ADDR0;
  assign aoff = dio_addr - sysctl_pkg::TADDR_ADDR0;
  assign dsel = doff[1:0];
  assign asel = aoff[1:0];
  assign d_wr = dio_wr && doff[15:2] == 14'h0000;
  assign f_wr = dio_wr && dio_addr == sysctl_pkg::FLAG_ADDR;
  assign a_wr = dio_wr && aoff < 16'h0003;
  // RQ21 high byte triggers access
  assign ahi_wr = dio_wr && dio_addr == sysctl_pkg::TADDR_ADDR2;
  // go must carry the high byte being written, not the old one
  assign taddr_nxt = ahi_wr ? {dio_wdata, taddr_r[15:0]} : taddr_r;
  // RQ13 broadcast flag constant one
  assign sc_val = {swrst_r, load_r, start_r, clr_r, stsel_r, vdis_r, long_r, 1'b1};
  // RQ15 activity bit in flag
  assign flag_val = {act_r, 3'h0, test_flag_field_r};
  assign rd_mux = (dio_addr == sysctl_pkg::SYSCTL_ADDR) ? sc_val :
                  (doff[15:2] == 14'h0000) ? test_data_word_r[8*dsel +: 8] :
                  (dio_addr == sysctl_pkg::FLAG_ADDR) ? flag_val :
                  (aoff < 16'h0003) ? taddr_r[8*asel +: 8] : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // system control
  always_ff @(posedge mclk)
  begin
    if (!rst_n || (ce && hw_wr))
    begin
      swrst_r <= 1'b0;
      load_r <= 1'b0;
      start_r <= 1'b0;
      clr_r <= 1'b0;
      stsel_r <= 1'b0;
      vdis_r <= 1'b0;
      long_r <= 1'b0;
      running_r <= 1'b0;
    end
    else if (ce)
    begin
      if (sc_wr)
      begin
        // RQ1 soft reset level
        swrst_r <= dio_wdata[sysctl_pkg::BIT_SWRST];
        // RQ7 clear repeats while set
        clr_r <= dio_wdata[sysctl_pkg::BIT_CLR];
        // RQ8 statistic steering
        stsel_r <= dio_wdata[sysctl_pkg::BIT_STSEL];
        vdis_r <= dio_wdata[sysctl_pkg::BIT_VDIS];
        long_r <= dio_wdata[sysctl_pkg::BIT_LONG];
      end
      // RQ4 RQ5 load sticky until done
      if (sc_wr && dio_wdata[sysctl_pkg::BIT_LOAD])
        load_r <= 1'b1;
      else if (load_done)
        load_r <= 1'b0;
      // RQ6 start until init ends
      if (sc_wr && dio_wdata[sysctl_pkg::BIT_START])
        start_r <= 1'b1;
      else if (init_done)
        start_r <= 1'b0;
      // RQ1 ports stay off after soft reset until buffer init ends after the next start
      if (swrst_r)
        running_r <= 1'b0;
      else if (init_done && start_r)
        running_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // test access registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      test_data_word_r <= 32'h00000000;
      test_flag_field_r <= 4'h0;
      taddr_r <= 24'h000000;
      act_r <= 1'b0;
      dram_go_r <= 1'b0;
    end
    else if (ce)
    begin
      dram_go_r <= ahi_wr;
      // RQ14 forward pointer word
      if (d_wr)
        test_data_word_r[8*dsel +: 8] <= dio_wdata;
      else if (dram_done && !taddr_r[sysctl_pkg::BIT_RW])
        test_data_word_r <= dram_rd_data;
      // RQ17 flag field
      if (f_wr)
        test_flag_field_r <= dio_wdata[3:0];
      else if (dram_done && !taddr_r[sysctl_pkg::BIT_RW])
        test_flag_field_r <= dram_rd_flag;
      if (a_wr)
        taddr_r[8*asel +: 8] <= dio_wdata;
      // RQ15 active until completion, start wins
      if (ahi_wr)
        act_r <= 1'b1;
      else if (dram_done)
        act_r <= 1'b0;
    end
  end

  // RQ15 trigger raises activity
  AST_ACT_SET: assert property (@(posedge mclk) disable iff (!rst_n) // RQ15
    ce && ahi_wr |=> act_r)
    else $error("activity not raised");
  // RQ15 completion drops activity
  AST_ACT_CLR: assert property (@(posedge mclk) disable iff (!rst_n) // RQ15
    ce && dram_done && !ahi_wr |=> !act_r)
    else $error("activity not cleared");
  // RQ21 high byte launches access
  AST_GO_PULSE: assert property (@(posedge mclk) disable iff (!rst_n) // RQ21
    ce && ahi_wr |=> dram_go_r)
    else $error("dram go missing");
  // RQ19 RQ20 address valid with go
  AST_ADDR_GO: assert property (@(posedge mclk) disable iff (!rst_n) // RQ19
    dram_go_r |-> dram_word_addr_r == {1'b0, taddr_r[21:0]})
    else $error("go with stale address");
  // RQ18 direction valid with go
  AST_DIR_GO: assert property (@(posedge mclk) disable iff (!rst_n) // RQ18
    dram_go_r |-> dram_write_r == taddr_r[sysctl_pkg::BIT_RW])
    else $error("go with stale direction");
  // RQ14 read completion loads data
  AST_RD_DATA: assert property (@(posedge mclk) disable iff (!rst_n) // RQ14
    ce && dram_done && !taddr_r[sysctl_pkg::BIT_RW] && !d_wr |=>
    test_data_word_r == $past(dram_rd_data))
    else $error("read data not loaded");
  // RQ17 read completion loads flag
  AST_RD_FLAG: assert property (@(posedge mclk) disable iff (!rst_n) // RQ17
    ce && dram_done && !taddr_r[sysctl_pkg::BIT_RW] && !f_wr |=>
    test_flag_field_r == $past(dram_rd_flag))
    else $error("read flag not loaded");
  // RQ13 broadcast flag reads one
  AST_IOB_ONE: assert property (@(posedge mclk) disable iff (!rst_n) // RQ13
    ce && dio_rd && dio_addr == sysctl_pkg::SYSCTL_ADDR |=> dio_rdata_r[0])
    else $error("broadcast flag not one");
  // RQ5 load set by one write
  AST_LOAD_SET: assert property (@(posedge mclk) disable iff (!rst_n) // RQ5
    ce && sc_wr && dio_wdata[sysctl_pkg::BIT_LOAD] |=> load_r)
    else $error("load not set");
  // RQ5 load held until done
  AST_LOAD_HOLD: assert property (@(posedge mclk) disable iff (!rst_n) // RQ5
    load_r && !load_done && !hw_wr && ce |=> load_r)
    else $error("load dropped");
  // RQ4 load launches the auto-load
  AST_LOAD_GO: assert property (@(posedge mclk) disable iff (!rst_n) // RQ4
    ce && sc_wr && dio_wdata[sysctl_pkg::BIT_LOAD] && !load_r |=> load_go_r)
    else $error("load go missing");
  // RQ4 no relaunch while busy
  AST_LOAD_ONCE: assert property (@(posedge mclk) disable iff (!rst_n) // RQ4
    ce && load_r |=> !load_go_r)
    else $error("load go while busy");
  // RQ6 start set by one write
  AST_START_SET: assert property (@(posedge mclk) disable iff (!rst_n) // RQ6
    ce && sc_wr && dio_wdata[sysctl_pkg::BIT_START] |=> start_r)
    else $error("start not set");
  // RQ6 start held until init ends
  AST_START_HOLD: assert property (@(posedge mclk) disable iff (!rst_n) // RQ6
    start_r && !init_done && !hw_wr && ce |=> start_r)
    else $error("start dropped");
  // RQ6 RQ1 ports off in init and reset
  AST_PORTS_OFF: assert property (@(posedge mclk) disable iff (!rst_n) // RQ6
    ce && (start_r || swrst_r) |=> ports_off_r)
    else $error("ports not off");
  // RQ1 soft reset stops running
  AST_RUN_CLR: assert property (@(posedge mclk) disable iff (!rst_n) // RQ1
    ce && swrst_r |=> !running_r)
    else $error("running kept in soft reset");
  // RQ2 soft reset clears port control
  AST_PORT_CLR: assert property (@(posedge mclk) disable iff (!rst_n) // RQ2
    ce && swrst_r |=> port_ctl_clear_r)
    else $error("port control not cleared");
  // RQ3 hardware reset range clears
  AST_HWRST: assert property (@(posedge mclk) disable iff (!rst_n) // RQ3
    ce && hw_wr |=> !clr_r && !stsel_r && !swrst_r)
    else $error("hw reset no clear");
  // RQ3 hardware reset reported
  AST_HWRST_OUT: assert property (@(posedge mclk) disable iff (!rst_n) // RQ3
    ce && hw_wr |=> hw_reset_r)
    else $error("hw reset not reported");
  // RQ7 clear driven while set
  AST_CLR_OUT: assert property (@(posedge mclk) disable iff (!rst_n) // RQ7
    ce && clr_r |=> stats_clear_r)
    else $error("stats clear not driven");
  // RQ8 statistic select driven
  AST_STSEL_OUT: assert property (@(posedge mclk) disable iff (!rst_n) // RQ8
    ce && stsel_r |=> stat_select_r)
    else $error("stat select not driven");

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      dio_rdata_r <= 8'h00;
      load_go_r <= 1'b0;
      hw_reset_r <= 1'b0;
      port_ctl_clear_r <= 1'b0;
      ports_off_r <= 1'b1;
      stats_clear_r <= 1'b0;
      stat_select_r <= 1'b0;
      dram_write_r <= 1'b0;
      dram_word_addr_r <= 23'h000000;
    end
    else if (ce)
    begin
      if (dio_rd)
        dio_rdata_r <= rd_mux;
      load_go_r <= sc_wr && dio_wdata[sysctl_pkg::BIT_LOAD] && !load_r;
      hw_reset_r <= hw_wr;
      // RQ2 soft reset clears port control only
      port_ctl_clear_r <= swrst_r;
      // RQ1 RQ6 ports held off
      ports_off_r <= swrst_r || start_r || !running_r;
      stats_clear_r <= clr_r;
      stat_select_r <= stsel_r;
      // RQ18 direction bit
      dram_write_r <= taddr_nxt[sysctl_pkg::BIT_RW];
      // RQ19 RQ20 column, row, extension bits passed as laid out
      dram_word_addr_r <= {1'b0, taddr_nxt[21:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // leaf blocks
  viol_port u_viol
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .violation_disable(vdis_r),
    .viol(viol),
    .mgmt_enable(mgmt_enable),
    .disabled_r(port_disabled_r),
    .suspended_r(port_suspended_r)
  );

  size_bucket u_size
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .long_mode(long_r),
    .len_valid(len_valid),
    .frame_len(frame_len),
    .bucket_hit_r(bucket_hit_r),
    .truncate_r(truncate_r)
  );
endmodule

//--- bench/engine_model.sv
/*
  Behavioural EEPROM-load and DRAM engines answering the register bank.
  Assumes go pulses are one cycle wide; alternates slow and prompt answers.
*/
`timescale 1ns/1ps
module engine_model
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // requests
  input wire logic load_go_r,
  input wire logic dram_go_r,
  input wire logic [22:0] dram_word_addr_r,
  // answers
  output logic load_done,
  output logic dram_done,
  output logic [31:0] dram_rd_data,
  output logic [3:0] dram_rd_flag
);
  logic [4:0] lcnt_r;
  logic [4:0] dcnt_r;
  logic [2:0] ops_r;
  logic [22:0] a_r;
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      lcnt_r <= 5'h00;
      dcnt_r <= 5'h00;
      ops_r <= 3'h0;
      a_r <= 23'h0;
      load_done <= 1'b0;
      dram_done <= 1'b0;
      dram_rd_data <= 32'h0;
      dram_rd_flag <= 4'h0;
    end
    else
    begin
      load_done <= (lcnt_r == 5'h01);
      lcnt_r <= load_go_r ? (ops_r[0] ? 5'h02 : 5'h0C) : lcnt_r - 5'(lcnt_r != 5'h00);
      dram_done <= (dcnt_r == 5'h01);
      dram_rd_data <= (dcnt_r == 5'h01) ? {~a_r[15:0], a_r[15:0]} : ~dram_rd_data;
      dram_rd_flag <= (dcnt_r == 5'h01) ? (a_r[3:0] ^ a_r[21:18]) : ~dram_rd_flag;
      dcnt_r <= dram_go_r ? (ops_r[0] ? 5'h02 : 5'h0C) : dcnt_r - 5'(dcnt_r != 5'h00);
      if (dram_go_r)
        a_r <= dram_word_addr_r;
      if (load_go_r || dram_go_r)
        ops_r <= ops_r + 3'h1;
    end
  end
endmodule

//--- bench/sysctl_regs_test.sv
/*
  Self-checking bench for the system control and DRAM test registers.
  Assumes the engine model answers load and DRAM requests.
*/
`timescale 1ns/1ps
module sysctl_regs_test;
  logic mclk = 0, rst_n = 0, ce = 1, dio_wr = 0, dio_rd = 0, init_done = 0;
  logic viol = 0, mgmt_enable = 0, len_valid = 0, sb = 0, st = 0, sh = 0;
  logic [15:0] dio_addr = 16'h0;
  logic [7:0] dio_wdata = 8'h0, r, v;
  logic [10:0] frame_len = 11'h0;
  logic [31:0] seed, dv, ad;
  logic [10:0] lens [8] = '{1023, 1024, 1518, 1519, 1531, 1532, 1535, 1536};
  logic [7:0] dio_rdata_r;
  logic [31:0] dram_rd_data, test_data_word_r;
  logic [3:0] dram_rd_flag, test_flag_field_r;
  logic [22:0] dram_word_addr_r;
  logic load_done, dram_done, load_go_r, dram_go_r, dram_write_r, hw_reset_r;
  logic port_ctl_clear_r, ports_off_r, stats_clear_r, stat_select_r;
  logic port_disabled_r, port_suspended_r, bucket_hit_r, truncate_r;
  int num_errors = 0, checked = 0;
  always #5 mclk = ~mclk;
  sysctl_regs sysctl_regs_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce), .dio_addr(dio_addr),
    .dio_wr(dio_wr), .dio_rd(dio_rd), .dio_wdata(dio_wdata), .dio_rdata_r(dio_rdata_r),
    .load_done(load_done), .init_done(init_done), .dram_done(dram_done),
    .dram_rd_data(dram_rd_data), .dram_rd_flag(dram_rd_flag), .load_go_r(load_go_r),
    .dram_go_r(dram_go_r), .dram_write_r(dram_write_r), .dram_word_addr_r(dram_word_addr_r),
    .test_data_word_r(test_data_word_r), .test_flag_field_r(test_flag_field_r),
    .hw_reset_r(hw_reset_r), .port_ctl_clear_r(port_ctl_clear_r), .ports_off_r(ports_off_r),
    .stats_clear_r(stats_clear_r), .stat_select_r(stat_select_r), .viol(viol),
    .mgmt_enable(mgmt_enable), .port_disabled_r(port_disabled_r),
    .port_suspended_r(port_suspended_r), .len_valid(len_valid), .frame_len(frame_len),
    .bucket_hit_r(bucket_hit_r), .truncate_r(truncate_r));
  engine_model engine_model_inst (.mclk(mclk), .rst_n(rst_n), .load_go_r(load_go_r),
    .dram_go_r(dram_go_r), .dram_word_addr_r(dram_word_addr_r), .load_done(load_done),
    .dram_done(dram_done), .dram_rd_data(dram_rd_data), .dram_rd_flag(dram_rd_flag));
  // one-cycle pulses are caught here
  always @(posedge mclk)
  begin
    if (bucket_hit_r) sb <= 1'b1;
    if (truncate_r) st <= 1'b1;
    if (hw_reset_r) sh <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  task close_out;
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task wr(logic [15:0] a, logic [7:0] d);
    @(posedge mclk);
    dio_addr <= a;
    dio_wdata <= d;
    dio_wr <= 1'b1;
    @(posedge mclk);
    dio_wr <= 1'b0;
  endtask
  task rd(logic [15:0] a, output logic [7:0] q);
    @(posedge mclk);
    dio_addr <= a;
    dio_rd <= 1'b1;
    @(posedge mclk);
    dio_rd <= 1'b0;
    @(posedge mclk);
    #1;
    q = dio_rdata_r;
  endtask
  // bounded poll of the activity bit; first read tells if it was seen busy
  task poll(output logic first);
    rd(sysctl_pkg::FLAG_ADDR, r);
    first = r[7];
    for (int i = 0; i < 40 && r[7] !== 1'b0; i++)
      rd(sysctl_pkg::FLAG_ADDR, r);
    if (r[7] !== 1'b0)
    begin
      num_errors++;
      close_out();
    end
  endtask
  task sz(logic [10:0] n, logic lg);
    @(posedge mclk);
    len_valid <= 1'b1;
    frame_len <= n;
    sb = 0;
    st = 0;
    @(posedge mclk);
    len_valid <= 1'b0;
    settle();
    chk("bucket", 32'(n >= 11'd1024 && n <= (lg ? 11'd1531 : 11'd1518)), 32'(sb));
    chk("trunc", 32'(n >= 11'd1536), 32'(st));
  endtask
  task addr_wr(logic [31:0] x);
    for (int i = 0; i < 3; i++)
      wr(sysctl_pkg::TADDR_ADDR0 + 16'(i), x[8*i +: 8]);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    logic b;
    seed = 32'h0196;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rd(sysctl_pkg::SYSCTL_ADDR, r);
    chk("sysctl_rst", 32'h01, 32'(r));
    for (int k = 0; k < 6; k++)
    begin
      v = 8'($random(seed)) & 8'h1E;
      wr(sysctl_pkg::SYSCTL_ADDR, v);
      rd(sysctl_pkg::SYSCTL_ADDR, r);
      chk("sysctl_rw", 32'(v | 8'h01), 32'(r));
      chk("stat_sel", 32'(v[3]), 32'(stat_select_r));
      chk("stats_clr", 32'(v[4]), 32'(stats_clear_r));
    end
    wr(sysctl_pkg::SYSCTL_ADDR, v | 8'h80);
    rd(sysctl_pkg::SYSCTL_ADDR, r);
    chk("swrst_keep", 32'(v | 8'h81), 32'(r));
    chk("port_clr", 32'h1, 32'(port_ctl_clear_r));
    wr(sysctl_pkg::SYSCTL_ADDR, v);
    settle();
    chk("off_after_swrst", 32'h1, 32'(ports_off_r));
    wr(sysctl_pkg::SYSCTL_ADDR, v | 8'h40);
    rd(sysctl_pkg::SYSCTL_ADDR, r);
    chk("load_busy", 32'h1, 32'(r[6]));
    repeat (20) @(posedge mclk);
    rd(sysctl_pkg::SYSCTL_ADDR, r);
    chk("load_done", 32'h0, 32'(r[6]));
    wr(sysctl_pkg::SYSCTL_ADDR, v | 8'h20);
    wr(sysctl_pkg::SYSCTL_ADDR, v);
    rd(sysctl_pkg::SYSCTL_ADDR, r);
    chk("start_busy", 32'h1, 32'(r[5]));
    chk("off_init", 32'h1, 32'(ports_off_r));
    @(posedge mclk);
    init_done <= 1'b1;
    @(posedge mclk);
    init_done <= 1'b0;
    rd(sysctl_pkg::SYSCTL_ADDR, r);
    chk("start_done", 32'h0, 32'(r[5]));
    chk("running", 32'h0, 32'(ports_off_r));
    wr(sysctl_pkg::SYSCTL_ADDR, v | 8'h80);
    wr(sysctl_pkg::SYSCTL_ADDR, v);
    rd(sysctl_pkg::SYSCTL_ADDR, r);
    chk("swrst_left", 32'(v | 8'h01), 32'(r));
    chk("off_run_swrst", 32'h1, 32'(ports_off_r));
    for (int k = 0; k < 2; k++)
    begin
      sh = 0;
      wr({k ? 2'b01 : 2'b10, 14'($random(seed))}, 8'hFF);
      settle();
      chk("hw_reset", 32'(k), 32'(sh));
    end
    rd(sysctl_pkg::SYSCTL_ADDR, r);
    chk("hw_cleared", 32'h01, 32'(r));
    dv = $random(seed);
    ad = $random(seed) | 32'h0080_0000;
    for (int i = 0; i < 4; i++)
      wr(sysctl_pkg::DATA_ADDR0 + 16'(i), dv[8*i +: 8]);
    wr(sysctl_pkg::FLAG_ADDR, dv[7:0]);
    addr_wr(ad);
    settle();
    chk("data_word", dv, test_data_word_r);
    chk("flag_field", 32'(dv[3:0]), 32'(test_flag_field_r));
    chk("dir_write", 32'h1, 32'(dram_write_r));
    chk("word_addr", {10'h0, ad[21:0]}, 32'(dram_word_addr_r));
    // wait for idle before next access
    poll(b);
    ad = $random(seed) & 32'h007F_FFFF;
    addr_wr(ad);
    poll(b);
    chk("act_busy", 32'h1, 32'(b));
    chk("dir_read", 32'h0, 32'(dram_write_r));
    for (int i = 0; i < 4; i++)
    begin
      rd(sysctl_pkg::DATA_ADDR0 + 16'(i), r);
      chk("rd_data", 32'({~ad[15:0], ad[15:0]} >> (8 * i)) & 32'hFF, 32'(r));
    end
    rd(sysctl_pkg::FLAG_ADDR, r);
    chk("rd_flag", 32'(ad[3:0] ^ ad[21:18]), 32'(r));
    for (int lg = 0; lg < 2; lg++)
    begin
      wr(sysctl_pkg::SYSCTL_ADDR, 8'(lg * 2));
      for (int i = 0; i < 8; i++)
        sz(lens[i], lg[0]);
      sz(11'($random(seed)), lg[0]);
    end
    for (int sd = 1; sd >= 0; sd--)
    begin
      wr(sysctl_pkg::SYSCTL_ADDR, 8'(sd * 4));
      @(posedge mclk);
      viol <= 1'b1;
      settle();
      chk("suspend", 32'(1 - sd), 32'(port_suspended_r));
      @(posedge mclk);
      viol <= 1'b0;
      settle();
      chk("held_off", 32'(sd), 32'(port_disabled_r));
      chk("resumed", 32'h0, 32'(port_suspended_r));
      @(posedge mclk);
      mgmt_enable <= 1'b1;
      @(posedge mclk);
      mgmt_enable <= 1'b0;
      settle();
      chk("mgmt_en", 32'h0, 32'(port_disabled_r));
    end
    close_out();
  end
endmodule
